// *** rtl/bac_defines.vh ***
// Register offsets, field positions, reset values and sizes for the button config block
`ifndef BAC_DEFINES_VH
`define BAC_DEFINES_VH
`define BAC_ADDR_W 8
`define BAC_DATA_W 8
`define BAC_OFF_SAMPLING_DIVIDER 8'h17
`define BAC_OFF_THRESHOLD_RELEASE_MARGIN 8'h18
`define BAC_OFF_TORSION_GUARD 8'h19
`define BAC_OFF_SHIFT_BEND_GROUP_SELECT 8'h1a
`define BAC_RST_SAMPLING_DIVIDER 8'h03
`define BAC_RST_THRESHOLD_RELEASE_MARGIN 8'h08
`define BAC_RST_TORSION_GUARD 8'h00
`define BAC_RST_SHIFT_BEND_GROUP_SELECT 8'h00
`define BAC_DIV_MSB 2
`define BAC_MARGIN_MSB 3
`define BAC_TWIST_MSB 2
`define BAC_COMMON_LSB 4
`define BAC_BEND_LSB 0
`define BAC_NUM_CH 4
`define BAC_CYC_W 5
`define BAC_VAL_W 16
`define BAC_WIN_W 13
`define BAC_REG_CNT 4
`endif

// *** rtl/bac_reg_mem.v ***
// Four-word register store with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "bac_defines.vh"
module bac_reg_mem (
  // Clock and reset
  input wire clk_sys_i,
  input wire rstn_i,
  // Write port
  input wire wr_en_i,
  input wire [1:0] wr_idx_i,
  input wire [`BAC_DATA_W-1:0] wr_data_i,
  // Read port
  input wire [1:0] rd_idx_i,
  output reg [`BAC_DATA_W-1:0] rd_data_o,
  // Whole contents for the algorithm
  output wire [`BAC_DATA_W*`BAC_REG_CNT-1:0] all_o
);
  reg [`BAC_DATA_W-1:0] mem_r [0:`BAC_REG_CNT-1];
  genvar g;
  generate
    for (g = 0; g < `BAC_REG_CNT; g = g + 1) begin : g_word
      assign all_o[g*`BAC_DATA_W +: `BAC_DATA_W] = mem_r[g];
    end
  endgenerate
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      mem_r[0] <= `BAC_RST_SAMPLING_DIVIDER;
      mem_r[1] <= `BAC_RST_THRESHOLD_RELEASE_MARGIN;
      mem_r[2] <= `BAC_RST_TORSION_GUARD;
      mem_r[3] <= `BAC_RST_SHIFT_BEND_GROUP_SELECT;
      rd_data_o <= 8'h00;
    end else begin
      // Whole byte stored, reserved bits included
      if (wr_en_i) begin
        mem_r[wr_idx_i] <= wr_data_i;
      end
      rd_data_o <= mem_r[rd_idx_i];
    end
  end
endmodule
`default_nettype wire

// *** rtl/bac_button_config.v ***
// Button algorithm configuration registers with threshold, hysteresis and twist guard
`timescale 1ns/10ps
`default_nettype none
`include "bac_defines.vh"
module bac_button_config (
  // Clock and reset
  input wire clk_sys_i,
  input wire rstn_i,
  // Register port from the management interface
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [`BAC_ADDR_W-1:0] reg_addr_i,
  input wire [`BAC_DATA_W-1:0] reg_wdata_i,
  output reg [`BAC_DATA_W-1:0] reg_rdata_o,
  output reg reg_rvalid_o,
  // Per-channel sensor cycle counts, 4 x 5 bits
  input wire [`BAC_NUM_CH*`BAC_CYC_W-1:0] sensor_cycle_count_i,
  // Processed values, signed, 4 x 16 bits, with sample strobe
  input wire [`BAC_NUM_CH*`BAC_VAL_W-1:0] button_processed_value_i,
  input wire sample_valid_i,
  // Per-channel trigger thresholds, unsigned 4 x 16 bits
  input wire [`BAC_NUM_CH*`BAC_VAL_W-1:0] trigger_threshold_i,
  // Algorithm outputs
  output reg [`BAC_NUM_CH-1:0] press_indicator_pin_o,
  output reg twist_void_o,
  output reg [`BAC_NUM_CH*`BAC_WIN_W-1:0] sampling_window_o,
  output reg [`BAC_NUM_CH-1:0] common_shift_group_member_o,
  output reg [`BAC_NUM_CH-1:0] bend_compensation_member_o
);

  // ****************************************
  // Address decode
  // ****************************************
  // Slot codes: bit 2 marks a mapped offset, bits 1-0 pick the word
  localparam [2:0] SLOT_NONE = 3'h0;
  localparam [2:0] SLOT_DIV = 3'h4;
  localparam [2:0] SLOT_MARGIN = 3'h5;
  localparam [2:0] SLOT_TWIST = 3'h6;
  localparam [2:0] SLOT_GROUP = 3'h7;

  function [2:0] bac_decode;
    input [`BAC_ADDR_W-1:0] addr;
    begin
      case (addr)
        `BAC_OFF_SAMPLING_DIVIDER: bac_decode = SLOT_DIV;
        `BAC_OFF_THRESHOLD_RELEASE_MARGIN: bac_decode = SLOT_MARGIN;
        `BAC_OFF_TORSION_GUARD: bac_decode = SLOT_TWIST;
        `BAC_OFF_SHIFT_BEND_GROUP_SELECT: bac_decode = SLOT_GROUP;
        default: bac_decode = SLOT_NONE;
      endcase
    end
  endfunction

  // One channel's 16-bit lane out of a packed bus
  function [`BAC_VAL_W-1:0] bac_lane;
    input [`BAC_NUM_CH*`BAC_VAL_W-1:0] bus;
    input integer idx;
    begin
      bac_lane = bus[idx*`BAC_VAL_W +: `BAC_VAL_W];
    end
  endfunction

  wire [2:0] wr_dec = bac_decode(reg_addr_i);
  wire slot_hit = wr_dec[2];
  wire [1:0] slot_idx = wr_dec[1:0];
  wire mem_wr = reg_wr_i & slot_hit;
  wire [`BAC_DATA_W-1:0] mem_rdata;
  wire [`BAC_DATA_W*`BAC_REG_CNT-1:0] regs;
  reg rd_hit_r;
  reg rd_pend_r;

  // ****************************************
  // Register store
  // ****************************************
  // full byte storage
  bac_reg_mem u_mem (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .wr_en_i(mem_wr),
    .wr_idx_i(slot_idx),
    .wr_data_i(reg_wdata_i),
    .rd_idx_i(slot_idx),
    .rd_data_o(mem_rdata),
    .all_o(regs)
  );

  // ****************************************
  // Read return
  // ****************************************
  // Unmapped offsets read as zero, answered one cycle after the capture
  // Same-cycle write and read to one offset returns the old byte
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rd_hit_r <= 1'b0;
      rd_pend_r <= 1'b0;
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      rd_pend_r <= reg_rd_i;
      rd_hit_r <= slot_hit;
      reg_rvalid_o <= rd_pend_r;
      if (rd_pend_r) begin
        reg_rdata_o <= rd_hit_r ? mem_rdata : 8'h00;
      end
    end
  end

  // ****************************************
  // Field extraction
  // ****************************************
  wire [7:0] r_div = regs[7:0];
  wire [7:0] r_margin = regs[15:8];
  wire [7:0] r_twist = regs[23:16];
  wire [7:0] r_group = regs[31:24];
  wire [2:0] resonator_freq_divider = r_div[`BAC_DIV_MSB:0];
  wire [3:0] release_margin_code = r_margin[`BAC_MARGIN_MSB:0];
  wire [2:0] torsion_guard_level = r_twist[`BAC_TWIST_MSB:0];
  wire [`BAC_VAL_W-1:0] release_margin_code_amt = {10'h000, release_margin_code, 2'b00};

  // ****************************************
  // Twist guard
  // ****************************************
  // threshold times four
  wire [`BAC_VAL_W-1:0] twist_thr = {11'h000, torsion_guard_level, 2'b00};
  // Negated limit, one bit wider so the full threshold stays signed
  wire signed [`BAC_VAL_W:0] twist_lim = -$signed({1'b0, twist_thr});
  wire twist_on = (torsion_guard_level != 3'h0);

  // ****************************************
  // Per-channel algorithm
  // ****************************************
  wire [`BAC_NUM_CH-1:0] neg_hit;
  wire [`BAC_NUM_CH-1:0] press_nxt;
  wire [`BAC_NUM_CH*`BAC_WIN_W-1:0] win_nxt;

  genvar c;
  generate
    for (c = 0; c < `BAC_NUM_CH; c = c + 1) begin : g_ch
      wire [`BAC_VAL_W-1:0] raw = bac_lane(button_processed_value_i, c);
      // Sign-extended so it compares against the unsigned threshold
      wire signed [`BAC_VAL_W:0] val = {raw[`BAC_VAL_W-1], raw};
      wire signed [`BAC_VAL_W:0] thr = {1'b0, bac_lane(trigger_threshold_i, c)};
      wire signed [`BAC_VAL_W:0] rel = thr - $signed({1'b0, release_margin_code_amt});
      wire [`BAC_CYC_W-1:0] cyc = sensor_cycle_count_i[c*`BAC_CYC_W +: `BAC_CYC_W];
      // Doubled count, widened before the shift so no bit is lost
      wire [`BAC_WIN_W-1:0] win_base = {{(`BAC_WIN_W-`BAC_CYC_W-1){1'b0}}, cyc, 1'b0};
      wire at_thr = (val >= thr);
      wire above_rel = (val >= rel);
      assign neg_hit[c] = (val <= twist_lim);
      assign press_nxt[c] = press_indicator_pin_o[c] ? above_rel : at_thr;
      assign win_nxt[c*`BAC_WIN_W +: `BAC_WIN_W] = win_base << resonator_freq_divider;
    end
  endgenerate

  wire void_nxt = twist_on & (|neg_hit);
  reg [`BAC_NUM_CH-1:0] press_hold_nxt;
  reg twist_void_nxt;

  // ****************************************
  // Button decision
  // ****************************************
  // Outputs hold between samples so the pins never glitch
  always @* begin
    press_hold_nxt = press_indicator_pin_o;
    twist_void_nxt = twist_void_o;
    if (sample_valid_i) begin
      twist_void_nxt = void_nxt;
      if (void_nxt) begin
        press_hold_nxt = {`BAC_NUM_CH{1'b0}};
      end else begin
        press_hold_nxt = press_nxt;
      end
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      press_indicator_pin_o <= 4'h0;
      twist_void_o <= 1'b0;
    end else begin
      press_indicator_pin_o <= press_hold_nxt;
      twist_void_o <= twist_void_nxt;
    end
  end

  // ****************************************
  // Configuration outputs
  // ****************************************
  // Registered, so fields appear one cycle after the store takes a write
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sampling_window_o <= {(`BAC_NUM_CH*`BAC_WIN_W){1'b0}};
      common_shift_group_member_o <= 4'h0;
      bend_compensation_member_o <= 4'h0;
    end else begin
      sampling_window_o <= win_nxt;
      common_shift_group_member_o <= r_group[`BAC_COMMON_LSB +: `BAC_NUM_CH];
      bend_compensation_member_o <= r_group[`BAC_BEND_LSB +: `BAC_NUM_CH];
    end
  end
endmodule
`default_nettype wire

// *** test/bac_button_config_sva.sv ***
// Port-level checker for the button configuration block
`timescale 1ns/10ps
`default_nettype none
module bac_button_config_sva (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire reg_rvalid_o,
  input wire [19:0] sensor_cycle_count_i,
  input wire [63:0] button_processed_value_i,
  input wire sample_valid_i,
  input wire [63:0] trigger_threshold_i,
  input wire [3:0] press_indicator_pin_o,
  input wire twist_void_o,
  input wire [51:0] sampling_window_o,
  input wire [3:0] common_shift_group_member_o,
  input wire [3:0] bend_compensation_member_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // Divider shadow; window checked on lane 0 only
  logic [2:0] div_q;
  wire [12:0] win0 = {7'h00, sensor_cycle_count_i[4:0], 1'b0} << div_q;
  wire [63:0] v = button_processed_value_i;
  wire [15:0] thr0 = trigger_threshold_i[15:0];
  wire set0 = sample_valid_i && ($signed({v[15], v[15:0]}) >= $signed({1'b0, thr0}));
  wire neg = sample_valid_i && (v[15] | v[31] | v[47] | v[63]);
  always @(posedge clk_sys_i) begin
    if (!rstn_i)
      div_q <= 3'h3;
    else if (reg_wr_i && reg_addr_i == 8'h17)
      div_q <= reg_wdata_i[2:0];
  end
  property p_rd; reg_rd_i |-> ##2 reg_rvalid_o; endproperty
  a_rd: assert property (p_rd) else $error("read answer missing");
  property p_rv; reg_rvalid_o |-> $past(reg_rd_i, 2); endproperty
  a_rv: assert property (p_rv) else $error("read answer without request");
  property p_com; reg_wr_i && reg_addr_i == 8'h1a |->
    ##2 common_shift_group_member_o == $past(reg_wdata_i[7:4], 2); endproperty
  a_com: assert property (p_com) else $error("common group mismatch");
  property p_bend; reg_wr_i && reg_addr_i == 8'h1a |->
    ##2 bend_compensation_member_o == $past(reg_wdata_i[3:0], 2); endproperty
  a_bend: assert property (p_bend) else $error("bend group mismatch");
  property p_win; $past(rstn_i, 2) |-> sampling_window_o[12:0] == $past(win0); endproperty
  a_win: assert property (p_win) else $error("window mismatch");
  property p_set; $rose(press_indicator_pin_o[0]) |-> $past(set0); endproperty
  a_set: assert property (p_set) else $error("press below threshold");
  property p_hold; !sample_valid_i |=>
    $stable(press_indicator_pin_o) && $stable(twist_void_o); endproperty
  a_hold: assert property (p_hold) else $error("outputs moved without sample");
  property p_all; twist_void_o |-> press_indicator_pin_o == 4'h0; endproperty
  a_all: assert property (p_all) else $error("press during void");
  property p_neg; $rose(twist_void_o) |-> $past(neg); endproperty
  a_neg: assert property (p_neg) else $error("void without negative value");
endmodule
`default_nettype wire

// *** test/bac_button_config_tb_top.sv ***
// Self-checking bench for the button configuration block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module bac_button_config_tb_top;
  logic clk_sys_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0, sample_valid_i = 0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
  logic [19:0] sensor_cycle_count_i = 20'h57c25;
  logic [63:0] button_processed_value_i = 64'h0, trigger_threshold_i = {4{16'h0064}};
  wire [7:0] reg_rdata_o;
  wire reg_rvalid_o, twist_void_o;
  wire [3:0] press_indicator_pin_o, common_shift_group_member_o, bend_compensation_member_o;
  wire [51:0] sampling_window_o;
  int errors = 0, checked = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  bac_button_config uut (.clk_sys_i, .rstn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .reg_rvalid_o, .sensor_cycle_count_i, .button_processed_value_i,
    .sample_valid_i, .trigger_threshold_i, .press_indicator_pin_o, .twist_void_o,
    .sampling_window_o, .common_shift_group_member_o, .bend_compensation_member_o);
  task test_done;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i) {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
    @(negedge clk_sys_i) reg_wr_i = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys_i) {reg_rd_i, reg_addr_i} = {1'b1, a};
    @(negedge clk_sys_i) reg_rd_i = 0;
    // Bounded wait for the answer
    for (int i = 0; i < 4 && reg_rvalid_o !== 1'b1; i++) @(negedge clk_sys_i);
    if (reg_rvalid_o !== 1'b1) begin errors++; test_done; end
    `CHK(reg_rdata_o, e)
  endtask
  task smp(input logic [63:0] v, input logic [3:0] ep, input logic ev);
    @(negedge clk_sys_i) {button_processed_value_i, sample_valid_i} = {v, 1'b1};
    @(negedge clk_sys_i) sample_valid_i = 0;
    `CHK(press_indicator_pin_o, ep)
    `CHK(twist_void_o, ev)
  endtask
  task t_regs;
    rd(8'h17, 8'h03);
    `CHK(sampling_window_o[12:0], 13'h0050)
    rd(8'h18, 8'h08);
    rd(8'h19, 8'h00);
    rd(8'h1a, 8'h00);
    wr(8'h16, 8'hff);
    rd(8'h16, 8'h00);
  endtask
  task t_fields;
    wr(8'h17, 8'hf9);
    rd(8'h17, 8'hf9);
    `CHK(sampling_window_o[12:0], 13'h0014)
    `CHK(sampling_window_o[51:13], {13'h0028, 13'h007c, 13'h0004})
    wr(8'h17, 8'h07);
    repeat (2) @(negedge clk_sys_i);
    `CHK(sampling_window_o[12:0], 13'h0500)
    `CHK(sampling_window_o[51:13], {13'h0a00, 13'h1f00, 13'h0100})
    wr(8'h1a, 8'ha5);
    repeat (2) @(negedge clk_sys_i);
    `CHK(common_shift_group_member_o, 4'ha)
    `CHK(bend_compensation_member_o, 4'h5)
  endtask
  task t_release_margin_code;
    wr(8'h18, 8'hf2);
    smp(64'd99, 4'h0, 1'b0);
    smp(64'd100, 4'h1, 1'b0);
    smp(64'd92, 4'h1, 1'b0);
    smp(64'd91, 4'h0, 1'b0);
  endtask
  task t_twist;
    smp({16'hff9c, 32'h0, 16'd200}, 4'h1, 1'b0);
    wr(8'h19, 8'hfa);
    smp({16'hfff9, 32'h0, 16'd200}, 4'h1, 1'b0);
    smp({16'hfff8, 32'h0, 16'd200}, 4'h0, 1'b1);
    smp({48'h0, 16'd200}, 4'h1, 1'b0);
  endtask
  initial begin
    repeat (5) @(negedge clk_sys_i);
    rstn_i = 1;
    t_regs;
    t_fields;
    t_release_margin_code;
    t_twist;
    test_done;
  end
endmodule
bind bac_button_config bac_button_config_sva u_sva (.clk_sys_i, .rstn_i, .reg_wr_i, .reg_rd_i,
  .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .sensor_cycle_count_i,
  .button_processed_value_i, .sample_valid_i, .trigger_threshold_i, .press_indicator_pin_o,
  .twist_void_o, .sampling_window_o, .common_shift_group_member_o, .bend_compensation_member_o);
`default_nettype wire
